// ===== hw/imrp_regs.vh
`ifndef IMRP_REGS_VH
`define IMRP_REGS_VH
// ----------------------------------------
// direct register offsets (5-bit management address)
// ----------------------------------------
`define IMRP_CTRL_ADDR      5'h0D
`define IMRP_PORTAL_ADDR    5'h0E
// ----------------------------------------
// control register fields
// ----------------------------------------
`define IMRP_FUNC_MSB       15
`define IMRP_FUNC_LSB       14
`define IMRP_DEV_MSB        4
`define IMRP_DEV_LSB        0
`define IMRP_CTRL_RESET     16'h0000
`define IMRP_PORTAL_RESET   16'h0000
// ----------------------------------------
// function codes
// ----------------------------------------
`define IMRP_FUNC_ADDR      2'h0
`define IMRP_FUNC_DATA      2'h1
`define IMRP_FUNC_INC_RW    2'h2
`define IMRP_FUNC_INC_WR    2'h3
// ----------------------------------------
// extended devices and registers
// ----------------------------------------
`define IMRP_DEV_PMA        5'h01
`define IMRP_DEV_WOL        5'h1F
`define IMRP_PMA_CTRL1_REG  16'h0000
`define IMRP_LPI_BIT        12
`define IMRP_WOL_CTRL_REG   16'h0000
`define IMRP_WOL_MAC0_REG   16'h0019
`define IMRP_WOL_MAC1_REG   16'h001A
`define IMRP_WOL_MAC2_REG   16'h001B
`define IMRP_WOL_LINKUP_BIT 0
`endif

// ===== hw/imrp_ext_space.v
`timescale 1ns/1ps
`default_nettype none
`include "imrp_regs.vh"
// ----------------------------------------
// extended register space: the few implemented registers
// ----------------------------------------
module imrp_ext_space (
	input  wire        clock,      // management clock
	input  wire        reset_n,    // async reset, active low
	input  wire [4:0]  dev_sel,    // selected extended device
	input  wire [15:0] reg_addr,   // target register address
	input  wire        wr_stb,     // one-cycle write strobe
	input  wire [15:0] wr_data,    // write data
	output reg  [15:0] rd_data,    // combinational read data
	output wire [15:0] pma_ctrl1,  // pma/pmd control one contents
	output wire [15:0] wol_ctrl,   // wake_on_lan control contents
	output wire [47:0] wol_mac     // magic packet address
);
	reg [15:0] pma_ctrl1_reg;
	reg [15:0] wol_ctrl_reg;
	reg [15:0] mac_reg [0:2];
	wire       sel_pma = (dev_sel == `IMRP_DEV_PMA) && (reg_addr == `IMRP_PMA_CTRL1_REG);
	wire       sel_wol = (dev_sel == `IMRP_DEV_WOL) && (reg_addr == `IMRP_WOL_CTRL_REG);
	wire       in_mac  = (dev_sel == `IMRP_DEV_WOL) && (reg_addr >= `IMRP_WOL_MAC0_REG) &&
	                     (reg_addr <= `IMRP_WOL_MAC2_REG);
	wire [15:0] mac_off = reg_addr - `IMRP_WOL_MAC0_REG;
	wire [1:0]  mac_idx = mac_off[1:0];

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pma_ctrl1_reg <= 16'h0000;
			wol_ctrl_reg  <= 16'h0000;
		end else if (wr_stb) begin
			if (sel_pma)
				pma_ctrl1_reg <= wr_data;
			if (sel_wol)
				wol_ctrl_reg <= wr_data;
		end
	end

	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_mac
			always @(posedge clock or negedge reset_n) begin
				if (!reset_n)
					mac_reg[i] <= 16'h0000;
				else if (wr_stb && in_mac && (mac_idx == i))
					mac_reg[i] <= wr_data;
			end
		end
	endgenerate

	// unimplemented locations read zero and ignore writes
	always @* begin
		rd_data = 16'h0000;
		if (sel_pma)
			rd_data = pma_ctrl1_reg;
		else if (sel_wol)
			rd_data = wol_ctrl_reg;
		else if (in_mac)
			rd_data = mac_reg[mac_idx];
	end

	assign pma_ctrl1 = pma_ctrl1_reg;
	assign wol_ctrl  = wol_ctrl_reg;
	assign wol_mac   = {mac_reg[2], mac_reg[1], mac_reg[0]};
endmodule
`default_nettype wire

// ===== hw/imrp_portal.v
`timescale 1ns/1ps
`default_nettype none
`include "imrp_regs.vh"
module imrp_portal (
	input  wire        clock,           // management clock, 10 MHz
	input  wire        reset_n,         // async reset, active low
	input  wire [4:0]  mgmt_addr,       // direct register address from management decoder
	input  wire        mgmt_wr,         // one-cycle write strobe
	input  wire        mgmt_rd,         // one-cycle read strobe, ends the read
	input  wire [15:0] mgmt_wdata,      // write data
	output reg  [15:0] mgmt_rdata,      // read data, registered
	output wire        mgmt_hit,        // address belongs to this portal
	output wire        lpi_enable,      // low power idle enable
	output wire        wol_linkup_en,   // link-up triggers power_event_output
	output wire [47:0] wol_mac_addr     // magic packet address
);
	// ----------------------------------------
	// direct registers
	// ----------------------------------------
	reg  [15:0] ctrl_reg;
	reg  [15:0] target_reg;
	reg  [15:0] target_next;
	wire [15:0] ext_rdata;
	wire [15:0] pma_ctrl1;
	wire [15:0] wol_ctrl;
	wire [1:0]  func     = ctrl_reg[`IMRP_FUNC_MSB:`IMRP_FUNC_LSB];
	wire [4:0]  dev_sel  = ctrl_reg[`IMRP_DEV_MSB:`IMRP_DEV_LSB];
	wire        ctrl_sel = (mgmt_addr == `IMRP_CTRL_ADDR);
	wire        port_sel = (mgmt_addr == `IMRP_PORTAL_ADDR);
	wire        data_mode = (func != `IMRP_FUNC_ADDR);
	wire        ext_wr   = mgmt_wr && port_sel && data_mode;

	assign mgmt_hit = ctrl_sel || port_sel;

	// reserved bits 13:5 are kept as plain storage
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			ctrl_reg <= `IMRP_CTRL_RESET;
		else if (mgmt_wr && ctrl_sel)
			ctrl_reg <= mgmt_wdata;
	end

	// ----------------------------------------
	// target address and post-increment
	// ----------------------------------------
	// increments wrap at ffffh, which keeps the full 16-bit space reachable
	always @* begin
		target_next = target_reg;
		if (port_sel && (mgmt_wr || mgmt_rd)) begin
			case (func)
				`IMRP_FUNC_ADDR: begin
					if (mgmt_wr)
						target_next = mgmt_wdata;
				end
				`IMRP_FUNC_DATA: begin
					target_next = target_reg;
				end
				`IMRP_FUNC_INC_RW: begin
					target_next = target_reg + 16'h0001;
				end
				`IMRP_FUNC_INC_WR: begin
					if (mgmt_wr)
						target_next = target_reg + 16'h0001;
				end
				default: begin
					target_next = target_reg;
				end
			endcase
		end
	end

	always @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			target_reg <= `IMRP_PORTAL_RESET;
		else
			target_reg <= target_next;
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	// read data is sampled on the read strobe, before any increment lands
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			mgmt_rdata <= 16'h0000;
		else if (mgmt_rd) begin
			if (ctrl_sel)
				mgmt_rdata <= ctrl_reg;
			else if (port_sel && !data_mode)
				mgmt_rdata <= target_reg;
			else if (port_sel)
				mgmt_rdata <= ext_rdata;
			else
				mgmt_rdata <= 16'h0000;
		end
	end

	// ----------------------------------------
	// extended space (32 devices x 64k addresses decoded)
	// ----------------------------------------
	imrp_ext_space u_ext (
		.clock     (clock),
		.reset_n   (reset_n),
		.dev_sel   (dev_sel),
		.reg_addr  (target_reg),
		.wr_stb    (ext_wr),
		.wr_data   (mgmt_wdata),
		.rd_data   (ext_rdata),
		.pma_ctrl1 (pma_ctrl1),
		.wol_ctrl  (wol_ctrl),
		.wol_mac   (wol_mac_addr)
	);

	assign lpi_enable    = pma_ctrl1[`IMRP_LPI_BIT];
	assign wol_linkup_en = wol_ctrl[`IMRP_WOL_LINKUP_BIT];
endmodule
`default_nettype wire

// ===== dv/imrp_chk.sv
`timescale 1ns/1ps
`default_nettype none
module imrp_chk (
	input wire logic        clock,         // clock
	input wire logic        reset_n,       // reset, active low
	input wire logic [4:0]  mgmt_addr,     // address
	input wire logic        mgmt_wr,       // write strobe
	input wire logic        mgmt_rd,       // read strobe
	input wire logic [15:0] mgmt_wdata,    // write data
	input wire logic [15:0] mgmt_rdata,    // read data
	input wire logic        mgmt_hit,      // portal hit
	input wire logic        lpi_enable,    // lpi enable
	input wire logic        wol_linkup_en, // link-up event
	input wire logic [47:0] wol_mac_addr   // magic address
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	a_hit_decode: assert property (mgmt_hit == (mgmt_addr inside {5'h0D, 5'h0E}))
		else $error("hit decode wrong");
	a_miss_zero: assert property (mgmt_rd && !mgmt_hit |=> mgmt_rdata == 16'h0000)
		else $error("miss read not zero");
	a_rdata_hold: assert property (!mgmt_rd |=> $stable(mgmt_rdata))
		else $error("read data moved");
	a_lpi_hold: assert property (!mgmt_wr |=> $stable(lpi_enable))
		else $error("lpi moved");
	a_wol_hold: assert property (!mgmt_wr |=> $stable(wol_linkup_en))
		else $error("linkup moved");
	a_mac_hold: assert property (!mgmt_wr |=> $stable(wol_mac_addr))
		else $error("mac moved");
	a_ctrl_echo: assert property (mgmt_wr && mgmt_addr == 5'h0D ##2 mgmt_rd && mgmt_addr == 5'h0D
		|=> mgmt_rdata == $past(mgmt_wdata, 3))
		else $error("control readback wrong");
	a_miss_quiet: assert property (mgmt_wr && !mgmt_hit |=> $stable(lpi_enable)
		&& $stable(wol_linkup_en))
		else $error("miss write had effect");
endmodule
bind imrp_portal imrp_chk u_chk (.clock(clock), .reset_n(reset_n), .mgmt_addr(mgmt_addr),
	.mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
	.mgmt_hit(mgmt_hit), .lpi_enable(lpi_enable), .wol_linkup_en(wol_linkup_en),
	.wol_mac_addr(wol_mac_addr));
`default_nettype wire

// ===== dv/imrp_host.sv
`timescale 1ns/1ps
`default_nettype none
module imrp_host (
	input  wire logic        clock,      // clock
	output var  logic [4:0]  mgmt_addr,  // address
	output var  logic        mgmt_wr,    // write strobe
	output var  logic        mgmt_rd,    // read strobe
	output var  logic [15:0] mgmt_wdata  // write data
);
	initial begin
		mgmt_addr = 5'h00;
		mgmt_wr = 1'b0;
		mgmt_rd = 1'b0;
		mgmt_wdata = 16'h0000;
	end
	// idle lines wander so a stale address or data is never trusted
	task automatic access(input logic [4:0] a, input logic [15:0] d, input logic w);
		@(posedge clock);
		mgmt_addr <= a;
		mgmt_wdata <= d;
		mgmt_wr <= w;
		mgmt_rd <= !w;
		@(posedge clock);
		mgmt_wr <= 1'b0;
		mgmt_rd <= 1'b0;
		mgmt_addr <= 5'($urandom);
		mgmt_wdata <= 16'($urandom);
	endtask
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clock = 1'b0;
	logic        reset_n = 1'b0;
	logic        mgmt_wr, mgmt_rd, mgmt_hit, lpi_enable, wol_linkup_en, pend = 1'b0;
	logic [4:0]  mgmt_addr;
	logic [15:0] mgmt_wdata, mgmt_rdata, m0, m1, m2, v;
	logic [47:0] wol_mac_addr;
	logic [15:0] exp_q[$];
	int          fail_count = 0, n_tests = 0;
	always #50 clock = ~clock;
	imrp_host host (.clock(clock), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
		.mgmt_wdata(mgmt_wdata));
	imrp_portal dut (.clock(clock), .reset_n(reset_n), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
		.mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_hit(mgmt_hit),
		.lpi_enable(lpi_enable), .wol_linkup_en(wol_linkup_en), .wol_mac_addr(wol_mac_addr));
	task automatic chk(input string n, input logic [47:0] e, input logic [47:0] s);
		n_tests++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic w(input logic [4:0] a, input logic [15:0] d);
		host.access(a, d, 1'b1);
	endtask
	task automatic r(input logic [4:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		host.access(a, 16'h0000, 1'b0);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// read data is valid for the whole cycle after the strobe is taken
	always @(posedge clock) pend <= mgmt_rd;
	always @(negedge clock) if (pend) chk("rdata", exp_q.pop_front(), mgmt_rdata);
	initial begin
		#100000;
		fail_count++;
		give_verdict();
	end
	initial begin
		void'($urandom(47191));
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
		r(5'h0D, 16'h0000);
		r(5'h0E, 16'h0000);
		chk("lpi", 48'(lpi_enable), 48'h0);
		w(5'h0D, 16'h001F);
		w(5'h0E, 16'h0000);
		w(5'h0D, 16'h401F);
		w(5'h0E, 16'h0001);
		r(5'h0E, 16'h0001);
		r(5'h0E, 16'h0001);
		chk("linkup", 48'(wol_linkup_en), 48'h1);
		$display("test write sequence done");
		m0 = 16'($urandom);
		m1 = 16'($urandom);
		m2 = 16'($urandom);
		w(5'h0D, 16'h001F);
		w(5'h0E, 16'h0019);
		w(5'h0D, 16'hC01F);
		w(5'h0E, m0);
		w(5'h0E, m1);
		w(5'h0E, m2);
		r(5'h0E, 16'h0000);
		w(5'h0D, 16'h001F);
		r(5'h0E, 16'h001C);
		w(5'h0E, 16'h0019);
		w(5'h0D, 16'h801F);
		r(5'h0E, m0);
		r(5'h0E, m1);
		r(5'h0E, m2);
		w(5'h0D, 16'h001F);
		r(5'h0E, 16'h001C);
		chk("mac", wol_mac_addr, {m2, m1, m0});
		$display("test increment done");
		w(5'h0D, 16'h0001);
		w(5'h0E, 16'h0000);
		w(5'h0D, 16'h4001);
		w(5'h0E, 16'h1000);
		r(5'h0E, 16'h1000);
		chk("lpi", 48'(lpi_enable), 48'h1);
		w(5'h0D, 16'h0005);
		w(5'h0E, 16'hFFFF);
		w(5'h0D, 16'h8005);
		w(5'h0E, 16'h1234);
		r(5'h0E, 16'h0000);
		w(5'h0D, 16'h0005);
		r(5'h0E, 16'h0001);
		v = 16'($urandom);
		w(5'h03, v);
		r(5'h03, 16'h0000);
		w(5'h0D, v);
		r(5'h0D, v);
		$display("test unmapped done");
		@(posedge clock);
		@(posedge clock);
		give_verdict();
	end
endmodule
`default_nettype wire
